// ### design/ebt_pkg.sv
// constants and types shared by the eight-bit interval/pwm timer
package ebt_pkg;

    // ==========================================================
    // register byte offsets on the apb bus
    localparam logic [7:0] EBT_OFS_MODE    = 8'h00;
    localparam logic [7:0] EBT_OFS_CARRIER = 8'h04;
    localparam logic [7:0] EBT_OFS_CYCLE   = 8'h08;
    localparam logic [7:0] EBT_OFS_DUTY    = 8'h0c;
    localparam logic [7:0] EBT_OFS_COUNT   = 8'h10;
    localparam logic [7:0] EBT_OFS_STATUS  = 8'h14;

    // ==========================================================
    // values after reset
    localparam logic [7:0] EBT_RST_MODE    = 8'h00;
    localparam logic [7:0] EBT_RST_CARRIER = 8'h00;
    localparam logic [7:0] EBT_RST_CMP     = 8'h00;

    // ==========================================================
    // cycle counts in count-clock ticks
    localparam logic [1:0] EBT_DUTY_SETTLE = 2'h3;
    localparam logic [1:0] EBT_XFER_TICKS  = 2'h2;

    // ==========================================================
    // operating modes and count-clock selections
    typedef enum logic [1:0] {
        EBT_INTERVAL = 2'h0,
        EBT_CARRIER  = 2'h1,
        EBT_PWM      = 2'h2
    } ebt_mode_t;

    localparam logic [2:0] EBT_CK_DIV1    = 3'h0;
    localparam logic [2:0] EBT_CK_DIV2    = 3'h1;
    localparam logic [2:0] EBT_CK_DIV4    = 3'h2;
    localparam logic [2:0] EBT_CK_DIV16   = 3'h3;
    localparam logic [2:0] EBT_CK_DIV64   = 3'h4;
    localparam logic [2:0] EBT_CK_DIV1024 = 3'h5;

    // ==========================================================
    // register layouts
    typedef struct packed {
        logic       count_enable;
        logic [2:0] clock_select;
        logic [1:0] timer_mode_control;
        logic       default_level_select;
        logic       output_enable;
    } ebt_mode_reg_t;

    typedef struct packed {
        logic [4:0] zero;
        logic       remote_ctl_select;
        logic       level_buffer_bit;
        logic       carrier_status_flag;
    } ebt_carrier_reg_t;

    // compare phase, gray along stop -> cycle -> duty
    typedef enum logic [1:0] {
        EBT_ST_STOP  = 2'h0,
        EBT_ST_CYCLE = 2'h1,
        EBT_ST_DUTY  = 2'h3
    } ebt_state_t;

endpackage : ebt_pkg

// ### design/ebt_prescale.sv
// count-clock tick generator for the eight-bit timer
`timescale 1ns/1ps
module ebt_prescale
    import ebt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // control
    input  wire logic       run,
    input  wire logic [2:0] sel,
    // one-cycle count tick
    output logic            tick
);
    typedef struct packed {
        logic [9:0] div;
        logic       tick;
    } ebt_pre_t;

    ebt_pre_t   s;
    ebt_pre_t   next_s;
    logic [9:0] mask;

    // divider mask per selection; prohibited codes never tick
    always_comb begin
        next_s = s;
        case (sel)
            EBT_CK_DIV1:    mask = 10'h000;
            EBT_CK_DIV2:    mask = 10'h001;
            EBT_CK_DIV4:    mask = 10'h003;
            EBT_CK_DIV16:   mask = 10'h00f;
            EBT_CK_DIV64:   mask = 10'h03f;
            EBT_CK_DIV1024: mask = 10'h3ff;
            default:        mask = 10'h000;
        endcase
        // held at zero while stopped so the first tick is deterministic
        if (!run) begin
            next_s.div  = 10'h000;
            next_s.tick = 1'b0;
        end else begin
            next_s.div  = s.div + 10'h001;
            next_s.tick = ((s.div & mask) == mask) && (sel <= EBT_CK_DIV1024);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule : ebt_prescale

// ### design/ebt_duty_buf.sv
// buffered duty compare with delayed reload
`timescale 1ns/1ps
module ebt_duty_buf
    import ebt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // software write
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    // timer side
    input  wire logic       running,
    input  wire logic       tick,
    input  wire logic       reload,
    output logic [7:0]      duty
);
    typedef struct packed {
        logic [7:0] active;
        logic [7:0] pend;
        logic       valid;
        logic [1:0] age;
    } ebt_duty_t;

    ebt_duty_t s;
    ebt_duty_t next_s;

    always_comb begin
        next_s = s;
        if (wr && !running) begin
            // stopped timer takes the value at once
            next_s.active = wdata;
            next_s.valid  = 1'b0;
        end else if (wr) begin
            // a write in the reload cycle wins; transfer is skipped
            next_s.pend  = wdata;
            next_s.valid = 1'b1;
            next_s.age   = 2'h0;
        end else begin
            if (tick && s.valid && s.age != EBT_DUTY_SETTLE) begin
                next_s.age = s.age + 2'h1;
            end
            // only a value aged three ticks may move on the old match
            if (reload && s.valid && s.age == EBT_DUTY_SETTLE) begin
                next_s.active = s.pend;
                next_s.valid  = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign duty = s.active;

endmodule : ebt_duty_buf

// ### design/ebt_timer.sv
// eight-bit interval/pwm timer with carrier output control, apb slave
//
// Behaviour
// - carrier control resets to zero; status flag read-only, remote and level bits writable.
// - remote off: output follows level bit; remote on: low or carrier pulse.
// - status flag 0 means carrier disabled low, 1 means carrier enabled.
// - interval mode: cycle match raises interrupt and clears counter, repeating.
// - interval mode ignores duty compare matches entirely.
// - interval mode toggles output per cycle match, interrupt on the same match tick.
// - setting enable starts counting on the selected count clock.
// - clearing enable returns interrupt and output to default levels; carrier mode output still follows remote, level and status bits.
// - interval mode with cycle zero: counter stays zero, interrupt once.
// - pwm: first compare is cycle; match clears, interrupts, toggles, selects duty.
// - pwm duty match toggles, selects cycle, no clear, no interrupt.
// - pwm period is N+1 ticks, inactive to active width N-M to M+1.
// - duty writes while running are buffered, reloaded on old match after three ticks.
// - pwm output stays default until the first cycle match.
// - clearing enable stops and zeroes the counter; setting lets it count.
// - default level bit selects low or high default output.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ebt_timer
    import ebt_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input  wire logic              REF_CLK,
    input  wire logic              ARST_N,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // carrier transfer event from the partner counter
    input  wire logic              CARRIER_XFER,
    // timer outputs
    output logic                   TIMER_OUT,
    output logic                   TIMER_IRQ
);

    // ==========================================================
    // state
    typedef struct packed {
        ebt_mode_reg_t    mode;
        ebt_carrier_reg_t carrier;
        logic [7:0]       cycle_compare;
        logic [7:0]       count;
        ebt_state_t       state;
        logic             toggle;
        logic             zero_done;
        logic             irq;
        logic             out;
        logic             xfer_meta;
        logic             xfer_sync;
        logic             xfer_prev;
        logic             xfer_pend;
        logic [1:0]       xfer_cnt;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } ebt_state_reg_t;

    ebt_state_reg_t s;
    ebt_state_reg_t next_s;

    logic       tick;
    logic [7:0] duty_compare;
    logic       duty_wr;
    logic       duty_reload;
    logic       running;
    logic [7:0] addr;

    assign addr    = PADDR[7:0];
    assign running = (s.state != EBT_ST_STOP);

    // ==========================================================
    // count clock and duty buffer
    ebt_prescale u_pre (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .run    (s.mode.count_enable),
        .sel    (s.mode.clock_select),
        .tick   (tick)
    );

    ebt_duty_buf u_duty (
        .clk     (REF_CLK),
        .arst_n  (ARST_N),
        .wr      (duty_wr),
        .wdata   (PWDATA[7:0]),
        .running (running),
        .tick    (tick),
        .reload  (duty_reload),
        .duty    (duty_compare)
    );

    // ==========================================================
    // next-state logic
    always_comb begin
        logic       access;
        logic       mapped;
        logic [7:0] target;
        logic       match;
        logic       pulse;
        logic       carrier_out;
        access      = PSEL && PENABLE && s.pready;
        mapped      = 1'b0;
        target      = 8'h00;
        match       = 1'b0;
        pulse       = 1'b0;
        carrier_out = 1'b0;
        duty_wr     = 1'b0;
        duty_reload = 1'b0;
        next_s      = s;
        next_s.irq  = 1'b0;

        // address decode in the setup cycle, no wait state, so read data leave a flop
        case (addr)
            EBT_OFS_MODE, EBT_OFS_CARRIER, EBT_OFS_CYCLE,
            EBT_OFS_DUTY, EBT_OFS_COUNT, EBT_OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        if (PSEL && !PENABLE && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !mapped;
            case (addr)
                EBT_OFS_MODE:    next_s.prdata = {24'h000000, s.mode};
                EBT_OFS_CARRIER: next_s.prdata = {24'h000000, s.carrier};
                EBT_OFS_CYCLE:   next_s.prdata = {24'h000000, s.cycle_compare};
                EBT_OFS_DUTY:    next_s.prdata = {24'h000000, duty_compare};
                EBT_OFS_COUNT:   next_s.prdata = {24'h000000, s.count};
                EBT_OFS_STATUS:  next_s.prdata = {27'h0000000, s.zero_done,
                                                  s.state, s.toggle, s.out};
                default:         next_s.prdata = 32'h00000000;
            endcase
        end else if (access) begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
        end

        // register writes take effect in the access cycle
        if (access && PWRITE && mapped) begin
            case (addr)
                EBT_OFS_MODE: begin
                    // while running only the enable bit may change
                    if (s.mode.count_enable) begin
                        next_s.mode.count_enable = PWDATA[7];
                    end else begin
                        next_s.mode = PWDATA[7:0];
                    end
                end
                EBT_OFS_CARRIER: begin
                    next_s.carrier.remote_ctl_select = PWDATA[2];
                    next_s.carrier.level_buffer_bit  = PWDATA[1];
                end
                EBT_OFS_CYCLE: next_s.cycle_compare = PWDATA[7:0];
                EBT_OFS_DUTY:  duty_wr = 1'b1;
                default: ;
            endcase
        end

        // carrier transfer: level bit moves to status flag on 2nd tick
        next_s.xfer_meta = CARRIER_XFER;
        next_s.xfer_sync = s.xfer_meta;
        next_s.xfer_prev = s.xfer_sync;
        if (s.xfer_sync && !s.xfer_prev) begin
            next_s.xfer_pend = 1'b1;
            next_s.xfer_cnt  = 2'h0;
        end else if (s.xfer_pend && tick) begin
            if (s.xfer_cnt == EBT_XFER_TICKS - 2'h1) begin
                next_s.carrier.carrier_status_flag = s.carrier.level_buffer_bit;
                next_s.xfer_pend = 1'b0;
            end else begin
                next_s.xfer_cnt = s.xfer_cnt + 2'h1;
            end
        end

        // counter and compare sequencing
        if (!s.mode.count_enable) begin
            next_s.state     = EBT_ST_STOP;
            next_s.count     = 8'h00;
            next_s.toggle    = 1'b0;
            next_s.zero_done = 1'b0;
            next_s.irq       = 1'b0;
        end else if (s.state == EBT_ST_STOP) begin
            next_s.state = EBT_ST_CYCLE;
        end else if (tick) begin
            // interval mode never looks at the duty compare
            if (s.state == EBT_ST_DUTY &&
                s.mode.timer_mode_control != EBT_INTERVAL) begin
                target = duty_compare;
            end else begin
                target = s.cycle_compare;
            end
            match = (s.count == target);
            if (!match) begin
                next_s.count = s.count + 8'h01;
            end else if (s.mode.timer_mode_control == EBT_INTERVAL) begin
                next_s.count = 8'h00;
                // zero compare would match every tick; fire only once
                if (s.cycle_compare != 8'h00 || !s.zero_done) begin
                    next_s.irq       = 1'b1;
                    next_s.toggle    = !s.toggle;
                    next_s.zero_done = (s.cycle_compare == 8'h00);
                end
            end else if (s.state == EBT_ST_CYCLE) begin
                next_s.count  = 8'h00;
                next_s.irq    = 1'b1;
                next_s.toggle = !s.toggle;
                next_s.state  = EBT_ST_DUTY;
            end else begin
                // old duty value matched: buffered value may reload now
                duty_reload   = 1'b1;
                next_s.toggle = !s.toggle;
                next_s.state  = EBT_ST_CYCLE;
                if (s.mode.timer_mode_control == EBT_CARRIER) begin
                    next_s.count = 8'h00;
                    next_s.irq   = 1'b1;
                end else begin
                    next_s.count = s.count + 8'h01;
                end
            end
        end

        // output level: default unless enabled, then default xor toggle
        if (s.mode.output_enable) begin
            pulse = s.mode.default_level_select ^ next_s.toggle;
        end else begin
            pulse = s.mode.default_level_select;
        end
        if (next_s.carrier.carrier_status_flag) begin
            carrier_out = pulse;
        end else begin
            carrier_out = 1'b0;
        end
        if (s.mode.timer_mode_control != EBT_CARRIER) begin
            next_s.out = pulse;
        end else if (s.carrier.remote_ctl_select) begin
            next_s.out = carrier_out;
        end else begin
            next_s.out = s.carrier.level_buffer_bit;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s         <= '0;
            s.mode    <= EBT_RST_MODE;
            s.carrier <= EBT_RST_CARRIER;
            s.cycle_compare <= EBT_RST_CMP;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flops
    assign PRDATA    = s.prdata;
    assign PREADY    = s.pready;
    assign PSLVERR   = s.pslverr;
    assign TIMER_OUT = s.out;
    assign TIMER_IRQ = s.irq;

endmodule : ebt_timer

// ### dv/ebt_timer_asserts.sv
// port checker for the eight-bit timer
`timescale 1ns/1ps
module ebt_timer_asserts
    import ebt_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic              REF_CLK,
    input wire logic              ARST_N,
    // apb
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    // timer
    input wire logic              CARRIER_XFER,
    input wire logic              TIMER_OUT,
    input wire logic              TIMER_IRQ
);
    // ==========================================
    // shadow of the mode register, age since last write
    ebt_mode_reg_t m;
    logic [1:0]    age;
    logic          seen;
    logic          wr_mode;
    logic          run;
    logic          ival;
    logic          pwm;
    assign wr_mode = PSEL && PENABLE && PREADY && PWRITE && PADDR[7:0] == EBT_OFS_MODE;
    assign run     = age == 2'h3 && m.count_enable;
    assign ival    = m.timer_mode_control == EBT_INTERVAL;
    assign pwm     = m.timer_mode_control == EBT_PWM;
    // a running timer accepts only the enable bit
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            m    <= '0;
            age  <= 2'h0;
            seen <= 1'b0;
        end else begin
            if (wr_mode && m.count_enable) m.count_enable <= PWDATA[7];
            else if (wr_mode) m <= PWDATA[7:0];
            age  <= wr_mode ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
            seen <= m.count_enable && (seen || TIMER_IRQ);
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // ==========================================
    // register access
    property p_err;
        PREADY && PSLVERR |-> PADDR[7:0] > EBT_OFS_STATUS || PADDR[1:0] != 2'h0;
    endproperty
    a_err: assert property (p_err) else $error("slave error on a mapped address");
    property p_carrier_rd;
        PREADY && !PWRITE && PADDR[7:0] == EBT_OFS_CARRIER |-> PRDATA[31:3] == 29'h0;
    endproperty
    a_carrier_rd: assert property (p_carrier_rd) else $error("carrier read upper bits set");
    // ==========================================
    // stopped or disabled output (settle window covers the register stage)
    property p_stop;
        age == 2'h3 && !m.count_enable |-> !TIMER_IRQ;
    endproperty
    a_stop: assert property (p_stop) else $error("irq while stopped");
    property p_off;
        age == 2'h3 && (!m.count_enable || !m.output_enable) && m.timer_mode_control != EBT_CARRIER
            |-> TIMER_OUT == m.default_level_select;
    endproperty
    a_off: assert property (p_off) else $error("output not at default level");
    // ==========================================
    // interval mode: each match toggles, nothing else does
    property p_ival_tog;
        run && ival && m.output_enable && TIMER_IRQ |-> TIMER_OUT != $past(TIMER_OUT);
    endproperty
    a_ival_tog: assert property (p_ival_tog) else $error("interval match without toggle");
    property p_ival_cause;
        run && ival && $changed(TIMER_OUT) |-> TIMER_IRQ;
    endproperty
    a_ival_cause: assert property (p_ival_cause) else $error("interval toggle without match");
    // ==========================================
    // pwm mode phases
    property p_pwm_set;
        run && pwm && m.output_enable && TIMER_IRQ |-> TIMER_OUT != m.default_level_select;
    endproperty
    a_pwm_set: assert property (p_pwm_set) else $error("cycle match left output default");
    property p_pwm_duty;
        run && pwm && $changed(TIMER_OUT) && TIMER_OUT == m.default_level_select |-> !TIMER_IRQ;
    endproperty
    a_pwm_duty: assert property (p_pwm_duty) else $error("irq on duty match");
    property p_pwm_first;
        run && pwm && m.output_enable && !seen && !TIMER_IRQ |-> TIMER_OUT == m.default_level_select;
    endproperty
    a_pwm_first: assert property (p_pwm_first) else $error("output left default early");
endmodule : ebt_timer_asserts

bind ebt_timer ebt_timer_asserts #(.ADDR_W(ADDR_W)) u_asserts (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CARRIER_XFER(CARRIER_XFER), .TIMER_OUT(TIMER_OUT), .TIMER_IRQ(TIMER_IRQ));

// ### dv/ebt_timer_bench.sv
// self-checking bench for the eight-bit timer
`timescale 1ns/1ps
module ebt_timer_bench
    import ebt_pkg::*;
;
    logic        ref_clk, arst_n, psel, penable, pwrite, xfer;
    logic        pready, pslverr, tout, tirq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    int          n_mismatch, cmp_count, nirq, nhi, gap;

    ebt_timer #(.ADDR_W(8)) uut (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CARRIER_XFER(xfer), .TIMER_OUT(tout), .TIMER_IRQ(tirq));

    // ==========================================
    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================
    // compares and bus cycles
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_num(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_num
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk_val("prdata", {24'h0, exp}, rdat);
    endtask : rd
    // counts irq pulses, high cycles and the last irq spacing
    task automatic watch(input int n);
        int last;
        nirq = 0;
        nhi  = 0;
        gap  = 0;
        last = -1;
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            if (tirq === 1'b1) begin
                if (last >= 0) gap = i - last;
                last = i;
                nirq++;
            end
            if (tout === 1'b1) nhi++;
        end
    endtask : watch

    // ==========================================
    // scenarios
    task automatic t_regs;
        rd(EBT_OFS_CARRIER, 8'h00);
        wr(EBT_OFS_CARRIER, 8'hff);
        rd(EBT_OFS_CARRIER, 8'h06);
        apb(1'b0, 8'h20, 32'h0);
        chk_val("pslverr", 32'h1, {31'h0, err});
        wr(EBT_OFS_CARRIER, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_level;
        wr(EBT_OFS_MODE, 8'h02);
        repeat (4) @(posedge ref_clk);
        chk_val("timer out", 32'h1, {31'h0, tout});
        wr(EBT_OFS_MODE, 8'h00);
        repeat (4) @(posedge ref_clk);
        chk_val("timer out", 32'h0, {31'h0, tout});
        $display("test level done");
    endtask : t_level
    task automatic t_ival;
        wr(EBT_OFS_CYCLE, 8'h03);
        wr(EBT_OFS_MODE, 8'h81);
        repeat (12) @(posedge ref_clk);
        wr(EBT_OFS_DUTY, 8'h01);
        watch(40);
        chk_num("irq gap", 4, gap);
        chk_num("irq count", 10, nirq);
        chk_num("high cycles", 20, nhi);
        wr(EBT_OFS_MODE, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk_val("timer out", 32'h0, {31'h0, tout});
        rd(EBT_OFS_COUNT, 8'h00);
        $display("test interval done");
    endtask : t_ival
    task automatic t_zero;
        wr(EBT_OFS_CYCLE, 8'h00);
        wr(EBT_OFS_MODE, 8'h81);
        watch(40);
        chk_num("irq count", 1, nirq);
        rd(EBT_OFS_COUNT, 8'h00);
        wr(EBT_OFS_MODE, 8'h00);
        $display("test zero done");
    endtask : t_zero
    task automatic t_pwm;
        wr(EBT_OFS_CYCLE, 8'h07);
        wr(EBT_OFS_DUTY, 8'h02);
        wr(EBT_OFS_MODE, 8'h89);
        watch(6);
        chk_num("high cycles", 0, nhi);
        repeat (20) @(posedge ref_clk);
        watch(64);
        chk_num("period", 8, gap);
        chk_num("irq count", 8, nirq);
        chk_num("high cycles", 24, nhi);
        wr(EBT_OFS_DUTY, 8'h04);
        repeat (30) @(posedge ref_clk);
        watch(64);
        chk_num("high cycles", 40, nhi);
        rd(EBT_OFS_DUTY, 8'h04);
        wr(EBT_OFS_MODE, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk_val("timer out", 32'h0, {31'h0, tout});
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_carrier;
        wr(EBT_OFS_CYCLE, 8'h03);
        wr(EBT_OFS_DUTY, 8'h03);
        // count clock at half rate so the clock selection is exercised
        wr(EBT_OFS_MODE, 8'h95);
        wr(EBT_OFS_CARRIER, 8'h02);
        repeat (4) @(posedge ref_clk);
        chk_val("timer out", 32'h1, {31'h0, tout});
        wr(EBT_OFS_CARRIER, 8'h00);
        repeat (4) @(posedge ref_clk);
        chk_val("timer out", 32'h0, {31'h0, tout});
        wr(EBT_OFS_CARRIER, 8'h06);
        watch(32);
        chk_num("high cycles", 0, nhi);
        xfer <= 1'b1;
        repeat (8) @(posedge ref_clk);
        xfer <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(EBT_OFS_CARRIER, 8'h07);
        watch(32);
        chk_num("high cycles", 16, nhi);
        chk_num("irq gap", 8, gap);
        wr(EBT_OFS_MODE, 8'h00);
        $display("test carrier done");
    endtask : t_carrier

    // ==========================================
    // verdict, reached by the tests or the watchdog
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        arst_n     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        xfer       = 1'b0;
        n_mismatch = 0;
        cmp_count  = 0;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs;
        t_level;
        t_ival;
        t_zero;
        t_pwm;
        t_carrier;
        test_done;
    end
    // the tests need about 500 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        test_done;
    end
endmodule : ebt_timer_bench
